// file: pkg/rtu_slave_map.vh
`ifndef RTU_SLAVE_MAP_VH
`define RTU_SLAVE_MAP_VH
// ----------------------------------------
// read map indices
// ----------------------------------------
`define RD_PRODUCT 5'h00
`define RD_AQ_MEAS 5'h01
`define RD_TEMP_MEAS 5'h02
`define RD_AIR_LOOP 5'h03
`define RD_TEMP_LOOP 5'h04
`define RD_HUM_MEAS 5'h05
`define RD_HUM_HYST 5'h06
`define RD_AQ_THR 5'h07
`define RD_HUM_THR 5'h08
`define RD_NODE_ADDR 5'h0A
`define RD_AQ_FS 5'h0B
`define RD_TEMP_FS 5'h0C
`define RD_FROST 5'h12
`define RD_AO1_SEL 5'h13
`define RD_AO1_DO2_SEL 5'h14
`define RD_DO1_SEL 5'h15
`define RD_MAP_SIZE 17'h0001C
// ----------------------------------------
// write map indices
// ----------------------------------------
`define WR_NODE_ADDR 5'h00
`define WR_AQ_FS 5'h01
`define WR_TEMP_FS 5'h02
`define WR_FROST 5'h08
`define WR_AO1_SEL 5'h09
`define WR_MAP_SIZE 17'h00020
// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define RST_NODE_ADDR 16'h00F5
`define RST_AQ_FS 16'h0FA0
`define RST_TEMP_FS 16'h01F4
`define RST_FROST 16'h0010
`define RST_AO1_SEL 16'h0001
`define FIXED_OUT_SEL 16'h0065
`define FS_MAX 16'h7FFF
`define AIR_LOOP_MAX 16'h2710
`define TEMP_LOOP_MAX 16'h2710
`define TEMP_LOOP_MIN 16'hD8F0
`define HYST_DIV 16'h000A
// ----------------------------------------
// protocol constants
// ----------------------------------------
`define FN_READ 8'h03
`define FN_WRITE 8'h10
`define EXC_FLAG 8'h80
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define BCAST_ADDR 8'h00
`define MAX_WR_REGS 16'h0016
`define READ_REQ_LEN 7'h08
`define WRITE_HDR_LEN 7'h09
`define MIN_FRAME_LEN 7'h04
`define FRAME_DEPTH 7'h40
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define SIL_END_MUL 8'h02
`define SIL_START_NUM 8'h07
`define SIL_MAX 8'hFF
`endif

// file: design/rtu_slave.v
// Behaviour
// - transmit only in reply to addressed request
// - frame is address, function, data, check
// - binary framing only, no ascii
// - sixteen-bit crc in two trailing bytes
// - start collecting after 3.5 idle characters
// - accept own address or broadcast zero only
// - two idle characters end frame, check crc
// - good frame executes, reply echoes address, function
// - reply waits 3.5 characters after request end
// - parity, framing, overrun, crc errors: silent drop
// - exception reply: function plus 0x80, code
// - exception reply also waits 3.5 characters
// - read request: start, count, check field
// - read reply: byte count, data, check
// - write function accepts at most 22 registers
// - only 03 and 16; others get exception
// - read-only objects never change on write
// - humidity hysteresis is threshold divided by ten
// - air full scale up to 32767, bounds measurement
// - temperature in tenths, full scale default 500
// - loop outputs clamped 0..10000 and +-10000
// - config written through separate write map
`include "rtu_slave_map.vh"
`default_nettype none
module rtu_slave #(
  parameter [15:0] PRODUCT_CODE = 16'h0001 // arbitrary product identity value
) (
  input wire core_clk, // 10 MHz system clock
  input wire rstn, // asynchronous reset, active low
  input wire [15:0] bit_period, // clock cycles per serial bit, at least 1
  input wire [3:0] char_bits, // bits per character incl start, parity, stop
  input wire [7:0] rx_data, // received character
  input wire rx_valid, // one-cycle pulse per received character
  input wire rx_err, // parity, framing or overrun error with rx_valid
  output wire [7:0] tx_data, // reply byte to the uart
  output wire tx_valid, // reply byte is waiting
  input wire tx_ready, // uart takes tx_data this cycle
  output wire tx_drive_en, // line driver enable while replying
  input wire [15:0] air_quality_in, // measured air quality, ppm
  input wire [15:0] temperature_in, // measured temperature, tenths of a degree
  input wire [15:0] air_loop_in, // air quality controller output
  input wire [15:0] temp_loop_in, // temperature controller output, signed
  input wire [15:0] humidity_in, // measured humidity, % rh
  input wire [15:0] air_threshold_in, // air quality threshold setting
  input wire [15:0] humidity_threshold_in, // humidity threshold setting
  output wire [15:0] node_address, // configured bus address
  output wire [15:0] air_quality_full_scale, // air quality range
  output wire [15:0] temperature_full_scale, // temperature range
  output wire [15:0] frost_guard_min_temp, // frost guard temperature
  output wire [15:0] analog_out1_source_select // analog output 1 source
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_RECV = 8'h02;
  localparam [7:0] S_CHECK = 8'h04;
  localparam [7:0] S_EXEC = 8'h08;
  localparam [7:0] S_WRITE = 8'h10;
  localparam [7:0] S_GAP = 8'h20;
  localparam [7:0] S_SEND = 8'h40;
  localparam [7:0] S_DRAIN = 8'h80;
  localparam [1:0] K_READ = 2'h0;
  localparam [1:0] K_WRITE = 2'h1;
  localparam [1:0] K_EXC = 2'h2;

  // ----------------------------------------
  // shared decoding
  // ----------------------------------------
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1)
        x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
      crc_step = x;
    end
  endfunction

  reg [7:0] state_ff;
  reg [15:0] bit_cnt_ff;
  reg [7:0] sil_ff;
  reg [7:0] frm_ff [0:63];
  reg [6:0] rx_len_ff;
  reg rx_bad_ff;
  reg [15:0] crc_rx_ff;
  reg [1:0] kind_ff;
  reg [7:0] exc_code_ff;
  reg [4:0] wr_k_ff;
  reg [6:0] tx_idx_ff;
  reg [6:0] tx_len_ff;
  reg [15:0] crc_tx_ff;
  reg [15:0] node_addr_ff;
  reg [15:0] aq_fs_ff;
  reg [15:0] temp_fs_ff;
  reg [15:0] frost_ff;
  reg [15:0] ao1_sel_ff;
  reg [7:0] head_ff;
  reg head_v_ff;
  reg [7:0] tail_ff;
  reg tail_v_ff;

  wire [15:0] start_reg = {frm_ff[2], frm_ff[3]};
  wire [15:0] reg_cnt = {frm_ff[4], frm_ff[5]};
  wire [16:0] span_end = {1'b0, start_reg} + {1'b0, reg_cnt};
  wire [7:0] fn_code = frm_ff[1];
  wire is_bcast = (frm_ff[0] == `BCAST_ADDR);

  // ----------------------------------------
  // read map
  // ----------------------------------------
  wire [15:0] aq_meas = (air_quality_in > aq_fs_ff) ? aq_fs_ff : air_quality_in;
  wire [15:0] air_loop = (air_loop_in > `AIR_LOOP_MAX) ? `AIR_LOOP_MAX : air_loop_in;
  wire [15:0] temp_loop = ($signed(temp_loop_in) > $signed(`TEMP_LOOP_MAX)) ? `TEMP_LOOP_MAX :
                          ($signed(temp_loop_in) < $signed(`TEMP_LOOP_MIN)) ? `TEMP_LOOP_MIN : temp_loop_in;
  wire [15:0] hum_hyst = humidity_threshold_in / `HYST_DIV;

  function [15:0] reg_read;
    input [4:0] idx;
    begin
      case (idx)
        `RD_PRODUCT: reg_read = PRODUCT_CODE;
        `RD_AQ_MEAS: reg_read = aq_meas;
        `RD_TEMP_MEAS: reg_read = temperature_in;
        `RD_AIR_LOOP: reg_read = air_loop;
        `RD_TEMP_LOOP: reg_read = temp_loop;
        `RD_HUM_MEAS: reg_read = humidity_in;
        `RD_HUM_HYST: reg_read = hum_hyst;
        `RD_AQ_THR: reg_read = air_threshold_in;
        `RD_HUM_THR: reg_read = humidity_threshold_in;
        `RD_NODE_ADDR: reg_read = node_addr_ff;
        `RD_AQ_FS: reg_read = aq_fs_ff;
        `RD_TEMP_FS: reg_read = temp_fs_ff;
        `RD_FROST: reg_read = frost_ff;
        `RD_AO1_SEL: reg_read = ao1_sel_ff;
        `RD_AO1_DO2_SEL: reg_read = `FIXED_OUT_SEL;
        `RD_DO1_SEL: reg_read = `FIXED_OUT_SEL;
        default: reg_read = 16'h0000;
      endcase
    end
  endfunction

  // ----------------------------------------
  // silence timing
  // ----------------------------------------
  // the bit divider restarts on every character, so silence is measured from its end
  wire bit_tick = (bit_cnt_ff == bit_period - 16'h0001);
  wire [7:0] t_end = {4'h0, char_bits} * `SIL_END_MUL;
  wire [7:0] t_start_x2 = {4'h0, char_bits} * `SIL_START_NUM;
  wire [7:0] t_start = (t_start_x2 >> 1) + {7'h00, t_start_x2[0]};
  wire line_armed = (sil_ff >= t_start);
  wire frame_ended = (sil_ff >= t_end);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_ff <= 16'h0000;
      sil_ff <= 8'h00;
    end else if (rx_valid) begin
      bit_cnt_ff <= 16'h0000;
      sil_ff <= 8'h00;
    end else if (bit_tick) begin
      bit_cnt_ff <= 16'h0000;
      if (sil_ff != `SIL_MAX) sil_ff <= sil_ff + 8'h01;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // reply byte generator and buffer
  // ----------------------------------------
  wire buf_in_ready = ~tail_v_ff;
  wire buf_pop = head_v_ff & tx_ready;
  wire [6:0] data_rel = tx_idx_ff - 7'h03;
  wire [4:0] rd_idx = start_reg[4:0] + data_rel[5:1];
  wire [15:0] rd_word = reg_read(rd_idx);
  reg [7:0] tx_byte;

  always @* begin
    tx_byte = 8'h00;
    if (tx_idx_ff == tx_len_ff - 7'h02) tx_byte = crc_tx_ff[7:0];
    else if (tx_idx_ff == tx_len_ff - 7'h01) tx_byte = crc_tx_ff[15:8];
    else if (tx_idx_ff == 7'h00) tx_byte = frm_ff[0];
    else if (tx_idx_ff == 7'h01) tx_byte = (kind_ff == K_EXC) ? (fn_code | `EXC_FLAG) : fn_code;
    else begin
      case (kind_ff)
        K_READ: begin
          if (tx_idx_ff == 7'h02) tx_byte = {reg_cnt[6:0], 1'b0};
          else tx_byte = data_rel[0] ? rd_word[7:0] : rd_word[15:8];
        end
        K_WRITE: tx_byte = frm_ff[tx_idx_ff[2:0]];
        K_EXC: tx_byte = exc_code_ff;
        default: tx_byte = 8'h00;
      endcase
    end
  end

  wire buf_push = state_ff[6] & buf_in_ready;

  // two entries: a stalled uart holds the generator, no byte is dropped
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      head_ff <= 8'h00;
      head_v_ff <= 1'b0;
      tail_ff <= 8'h00;
      tail_v_ff <= 1'b0;
    end else if (buf_pop) begin
      if (tail_v_ff) begin
        head_ff <= tail_ff;
        tail_v_ff <= 1'b0;
      end else begin
        head_v_ff <= buf_push;
        head_ff <= tx_byte;
      end
    end else if (buf_push) begin
      if (!head_v_ff) begin
        head_ff <= tx_byte;
        head_v_ff <= 1'b1;
      end else begin
        tail_ff <= tx_byte;
        tail_v_ff <= 1'b1;
      end
    end
  end

  assign tx_data = head_ff;
  assign tx_valid = head_v_ff;
  assign tx_drive_en = state_ff[6] | state_ff[7];

  // ----------------------------------------
  // frame store
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_frm
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          frm_ff[g] <= 8'h00;
        // a new frame always lands at index 0, whatever length the last one left
        end else if (rx_valid && (state_ff[1] ? rx_len_ff : 7'h00) == g && (state_ff[1] || (state_ff[0] && line_armed))) begin
          frm_ff[g] <= rx_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // write map
  // ----------------------------------------
  wire [4:0] wr_reg = start_reg[4:0] + wr_k_ff;
  wire [5:0] wr_base = 6'h07 + {wr_k_ff, 1'b0};
  wire [15:0] wr_val = {frm_ff[wr_base], frm_ff[wr_base + 6'h01]};
  wire wr_fire = state_ff[4];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      node_addr_ff <= `RST_NODE_ADDR;
      aq_fs_ff <= `RST_AQ_FS;
      temp_fs_ff <= `RST_TEMP_FS;
      frost_ff <= `RST_FROST;
      ao1_sel_ff <= `RST_AO1_SEL;
    end else if (wr_fire) begin
      // internal and fixed entries of the write map are accepted and left unchanged
      case (wr_reg)
        `WR_NODE_ADDR: if (wr_val[15:8] == 8'h00 && wr_val[7:0] != `BCAST_ADDR) node_addr_ff <= wr_val;
        `WR_AQ_FS: if (wr_val <= `FS_MAX) aq_fs_ff <= wr_val;
        `WR_TEMP_FS: if (wr_val <= `FS_MAX) temp_fs_ff <= wr_val;
        `WR_FROST: frost_ff <= wr_val;
        `WR_AO1_SEL: ao1_sel_ff <= wr_val;
        default: ;
      endcase
    end
  end

  assign node_address = node_addr_ff;
  assign air_quality_full_scale = aq_fs_ff;
  assign temperature_full_scale = temp_fs_ff;
  assign frost_guard_min_temp = frost_ff;
  assign analog_out1_source_select = ao1_sel_ff;

  // ----------------------------------------
  // request sequencer
  // ----------------------------------------
  wire [6:0] wr_len = `WRITE_HDR_LEN + {reg_cnt[5:0], 1'b0};

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= S_IDLE;
      rx_len_ff <= 7'h00;
      rx_bad_ff <= 1'b0;
      crc_rx_ff <= `CRC_INIT;
      kind_ff <= K_READ;
      exc_code_ff <= 8'h00;
      wr_k_ff <= 5'h00;
      tx_idx_ff <= 7'h00;
      tx_len_ff <= 7'h00;
      crc_tx_ff <= `CRC_INIT;
    end else begin
      case (state_ff)
        S_IDLE: begin
          // characters before a full start silence are stray and dropped
          if (rx_valid && line_armed) begin
            state_ff <= S_RECV;
            rx_len_ff <= 7'h01;
            rx_bad_ff <= rx_err;
            crc_rx_ff <= crc_step(`CRC_INIT, rx_data);
          end
        end
        S_RECV: begin
          if (rx_valid) begin
            if (rx_len_ff != `FRAME_DEPTH) rx_len_ff <= rx_len_ff + 7'h01;
            rx_bad_ff <= rx_bad_ff | rx_err | (rx_len_ff == `FRAME_DEPTH);
            crc_rx_ff <= crc_step(crc_rx_ff, rx_data);
          end else if (frame_ended) begin
            state_ff <= S_CHECK;
          end
        end
        S_CHECK: begin
          // a frame whose crc runs over its own check bytes leaves zero
          if (rx_bad_ff || crc_rx_ff != 16'h0000 || rx_len_ff < `MIN_FRAME_LEN) begin
            state_ff <= S_IDLE;
          end else if (frm_ff[0] != node_addr_ff[7:0] && !is_bcast) begin
            state_ff <= S_IDLE;
          end else begin
            state_ff <= S_EXEC;
          end
        end
        S_EXEC: begin
          tx_idx_ff <= 7'h00;
          crc_tx_ff <= `CRC_INIT;
          wr_k_ff <= 5'h00;
          state_ff <= is_bcast ? S_IDLE : S_GAP;
          if (fn_code == `FN_READ) begin
            if (rx_len_ff != `READ_REQ_LEN || reg_cnt == 16'h0000 || reg_cnt > {11'h000, `RD_MAP_SIZE}) begin
              kind_ff <= K_EXC;
              exc_code_ff <= `EXC_VALUE;
              tx_len_ff <= 7'h05;
            end else if (span_end > `RD_MAP_SIZE) begin
              kind_ff <= K_EXC;
              exc_code_ff <= `EXC_ADDR;
              tx_len_ff <= 7'h05;
            end else begin
              kind_ff <= K_READ;
              tx_len_ff <= 7'h05 + {reg_cnt[5:0], 1'b0};
            end
          end else if (fn_code == `FN_WRITE) begin
            if (reg_cnt == 16'h0000 || reg_cnt > `MAX_WR_REGS || frm_ff[6] != {reg_cnt[6:0], 1'b0}
                || rx_len_ff != wr_len) begin
              kind_ff <= K_EXC;
              exc_code_ff <= `EXC_VALUE;
              tx_len_ff <= 7'h05;
            end else if (span_end > `WR_MAP_SIZE) begin
              kind_ff <= K_EXC;
              exc_code_ff <= `EXC_ADDR;
              tx_len_ff <= 7'h05;
            end else begin
              kind_ff <= K_WRITE;
              tx_len_ff <= 7'h08;
              state_ff <= S_WRITE;
            end
          end else begin
            kind_ff <= K_EXC;
            exc_code_ff <= `EXC_FUNC;
            tx_len_ff <= 7'h05;
          end
        end
        S_WRITE: begin
          wr_k_ff <= wr_k_ff + 5'h01;
          if ({11'h000, wr_k_ff} == reg_cnt - 16'h0001) state_ff <= is_bcast ? S_IDLE : S_GAP;
        end
        S_GAP: begin
          if (line_armed) state_ff <= S_SEND;
        end
        S_SEND: begin
          if (buf_push) begin
            tx_idx_ff <= tx_idx_ff + 7'h01;
            if (tx_idx_ff < tx_len_ff - 7'h02) begin
              crc_tx_ff <= crc_step(crc_tx_ff, tx_byte);
            end
            if (tx_idx_ff == tx_len_ff - 7'h01) begin
              state_ff <= S_DRAIN;
            end
          end
        end
        S_DRAIN: begin
          if (!head_v_ff && !tail_v_ff) state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // rtu_slave
`default_nettype wire

// file: test/rtu_slave_sva.sv
`default_nettype none
module rtu_slave_sva (
  input wire logic core_clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic [15:0] bit_period, // cycles per bit
  input wire logic [3:0] char_bits, // bits per character
  input wire logic [7:0] rx_data, // received character
  input wire logic rx_valid, // character strobe
  input wire logic rx_err, // character error
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply byte waiting
  input wire logic tx_ready, // reply byte taken
  input wire logic tx_drive_en, // line driver enable
  input wire logic [15:0] node_address, // own address
  input wire logic [15:0] air_quality_full_scale, // air range
  input wire logic [15:0] temperature_full_scale, // temperature range
  input wire logic [15:0] frost_guard_min_temp, // frost limit
  input wire logic [15:0] analog_out1_source_select // output select
);
  // ----------------------------------------
  // line silence and frame tracking
  // ----------------------------------------
  logic [31:0] quiet_ff, sil_start, sil_end;
  logic [1:0] ridx_ff;
  logic [7:0] fn_ff, bidx_ff;
  logic err_ff, exc_ff;
  assign sil_start = bit_period * ((32'd7 * char_bits + 32'd1) >> 1);
  assign sil_end = bit_period * 32'd2 * char_bits;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      quiet_ff <= 32'd0;
      ridx_ff <= 2'd0;
      fn_ff <= 8'h00;
      err_ff <= 1'b0;
      bidx_ff <= 8'h00;
      exc_ff <= 1'b0;
    end else begin
      quiet_ff <= rx_valid ? 32'd0 : (quiet_ff == 32'hFFFF_FFFF) ? quiet_ff : quiet_ff + 32'd1;
      if (rx_valid && quiet_ff >= sil_start) begin
        ridx_ff <= 2'd1;
        err_ff <= rx_err;
      end else if (rx_valid) begin
        ridx_ff <= (ridx_ff == 2'd3) ? ridx_ff : ridx_ff + 2'd1;
        err_ff <= err_ff | rx_err;
        if (ridx_ff == 2'd1) fn_ff <= rx_data;
      end
      bidx_ff <= !tx_drive_en ? 8'h00 : (tx_valid && tx_ready) ? bidx_ff + 8'h01 : bidx_ff;
      if (tx_valid && tx_ready && bidx_ff == 8'h01) exc_ff <= tx_data[7];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // slack for the bit-grained silence counter
  property p_gap; $rose(tx_drive_en) |-> quiet_ff + 32'd2 >= sil_start; endproperty
  property p_solicited; tx_valid |-> tx_drive_en; endproperty
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  property p_addr; tx_valid && bidx_ff == 8'h00 |-> tx_data == node_address[7:0]; endproperty
  property p_fn; tx_valid && bidx_ff == 8'h01 |-> tx_data[6:0] == fn_ff[6:0]; endproperty
  property p_exc; tx_valid && bidx_ff == 8'h02 && exc_ff |-> tx_data inside {8'h01, 8'h02, 8'h03}; endproperty
  property p_err; err_ff |-> !$rose(tx_drive_en); endproperty
  property p_cfg;
    !$stable({node_address, air_quality_full_scale, temperature_full_scale, frost_guard_min_temp,
      analog_out1_source_select}) |-> quiet_ff >= sil_end && !tx_drive_en;
  endproperty
  property p_rst;
    $rose(rstn) |-> !tx_valid && node_address == 16'h00F5 && air_quality_full_scale == 16'h0FA0 &&
      temperature_full_scale == 16'h01F4 && frost_guard_min_temp == 16'h0010 && analog_out1_source_select == 16'h0001;
  endproperty
  property p_fs; air_quality_full_scale <= 16'h7FFF && temperature_full_scale <= 16'h7FFF; endproperty
  a_gap: assert property (p_gap) else $error("reply started too soon");
  a_solicited: assert property (p_solicited) else $error("byte offered while not replying");
  a_hold: assert property (p_hold) else $error("stalled reply byte changed");
  a_addr: assert property (p_addr) else $error("reply address wrong");
  a_fn: assert property (p_fn) else $error("reply function not echoed");
  a_exc: assert property (p_exc) else $error("exception code out of set");
  a_err: assert property (p_err) else $error("reply to a damaged frame");
  a_cfg: assert property (p_cfg) else $error("configuration changed outside frame end");
  a_rst: assert property (p_rst) else $error("reset values wrong");
  a_fs: assert property (p_fs) else $error("full scale above limit");
  c_reply: cover property ($rose(tx_drive_en));
  c_stall: cover property (tx_valid && !tx_ready);
  c_exc: cover property (tx_valid && bidx_ff == 8'h02 && exc_ff);
endmodule // rtu_slave_sva
bind rtu_slave rtu_slave_sva rtu_slave_sva_inst (.*);
`default_nettype wire

// file: test/rtu_master_model.sv
`default_nettype none
module rtu_master_model (
  input wire logic core_clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic slow, // stall at random when high
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply byte waiting
  output logic tx_ready, // reply byte taken
  output logic got, // pulse per byte taken
  output logic [7:0] got_data // byte taken
);
  // random stalls mimic a busy uart
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      got <= 1'b0;
      got_data <= 8'h00;
    end else begin
      got <= tx_valid & tx_ready;
      got_data <= tx_data;
      tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule // rtu_master_model
`default_nettype wire

// file: test/tb_rtu_slave.sv
`default_nettype none
module tb_rtu_slave;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, rx_valid, rx_err, tx_valid, tx_ready, tx_drive_en, slow, got;
  logic [7:0] rx_data, tx_data, got_data;
  logic [3:0] char_bits;
  logic [15:0] bit_period, aq, tp, al, tl, hu, at, ht, node_address, aqfs, tfs, frost, ao1;
  logic [15:0] m_aqfs, m_tfs, m_frost, m_ao1;
  logic [15:0] w[$];
  logic [7:0] rq[$], ex[$], rsp[$];
  logic [7:0] fns[4] = '{8'h01, 8'h04, 8'h06, 8'h7F};
  int num_errors = 0, n_compared = 0, gap = 200;
  rtu_slave rtu_slave_inst (.core_clk, .rstn, .bit_period, .char_bits, .rx_data, .rx_valid, .rx_err, .tx_data,
    .tx_valid, .tx_ready, .tx_drive_en, .air_quality_in(aq), .temperature_in(tp), .air_loop_in(al),
    .temp_loop_in(tl), .humidity_in(hu), .air_threshold_in(at), .humidity_threshold_in(ht), .node_address,
    .air_quality_full_scale(aqfs), .temperature_full_scale(tfs), .frost_guard_min_temp(frost),
    .analog_out1_source_select(ao1));
  rtu_master_model rtu_master_model_inst (.core_clk, .rstn, .slow, .tx_data, .tx_valid, .tx_ready, .got, .got_data);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (got === 1'b1) rsp.push_back(got_data);
  // ----------------------------------------
  // expectations and checks
  // ----------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  function automatic logic [15:0] rd_val(input int i);
    case (i)
      0: return 16'h0001;
      1: return (aq > m_aqfs) ? m_aqfs : aq;
      2: return tp;
      3: return (al > 16'h2710) ? 16'h2710 : al;
      4: return ($signed(tl) > 16'sh2710) ? 16'h2710 : ($signed(tl) < -16'sh2710) ? 16'hD8F0 : tl;
      5: return hu;
      6: return ht / 16'h000A;
      7: return at;
      8: return ht;
      10: return 16'h00F5;
      11: return m_aqfs;
      12: return m_tfs;
      18: return m_frost;
      19: return m_ao1;
      20, 21: return 16'h0065;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic fail(input string m);
    num_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [15:0] v, input logic [15:0] e);
    n_compared++;
    if (v !== e) fail("register value mismatch");
  endtask
  task automatic chk_rsp();
    n_compared++;
    if (rsp.size() != ex.size()) fail("reply length mismatch");
    else foreach (ex[i]) if (rsp[i] !== ex[i]) fail("reply byte mismatch");
  endtask
  // ----------------------------------------
  // request builders and transfer
  // ----------------------------------------
  task automatic put(input logic [7:0] b, input logic e);
    rx_data <= b;
    rx_err <= e;
    rx_valid <= 1'b1;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    repeat (43) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] n);
    logic [15:0] v;
    rq = '{8'hF5, 8'h03, 8'h00, s, 8'h00, n};
    ex = '{8'hF5, 8'h03, 8'(2 * n)};
    for (int i = 0; i < n; i++) begin
      v = rd_val(s + i);
      ex.push_back(v[15:8]);
      ex.push_back(v[7:0]);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] s);
    rq = '{a, 8'h10, 8'h00, s, 8'h00, 8'(w.size()), 8'(2 * w.size())};
    foreach (w[i]) begin
      rq.push_back(w[i][15:8]);
      rq.push_back(w[i][7:0]);
    end
    ex = '{a, 8'h10, 8'h00, s, 8'h00, 8'(w.size())};
  endtask
  task automatic exc(input logic [7:0] f, input logic [7:0] c);
    ex = '{8'hF5, f | 8'h80, c};
  endtask
  // ex left empty means no reply may appear
  task automatic xfer(input logic bad, input int err_at);
    logic [15:0] c;
    int k;
    c = crc16(rq) ^ {15'h0000, bad};
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    if (ex.size() > 0) begin
      c = crc16(ex);
      ex.push_back(c[7:0]);
      ex.push_back(c[15:8]);
    end
    rsp.delete();
    repeat (gap) @(posedge core_clk);
    foreach (rq[i]) put(rq[i], i == err_at);
    for (k = 0; k < 800 && tx_drive_en !== 1'b1; k++) @(posedge core_clk);
    for (k = 0; k < 4000 && tx_drive_en === 1'b1; k++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk_rsp();
    rq.delete();
    ex.delete();
    $display("test done at %0t", $time);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    fail("watchdog expired");
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(40106));
    {rstn, rx_valid, rx_err, rx_data, slow, aq, tp, al, tl, hu, at, ht} = '0;
    bit_period = 16'h0004;
    char_bits = 4'hB;
    {m_aqfs, m_tfs, m_frost, m_ao1} = {16'h0FA0, 16'h01F4, 16'h0010, 16'h0001};
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk_val(node_address, 16'h00F5);
    repeat (3) begin
      {aq, tp, al, tl, hu, at, ht} <= {$urandom, $urandom, $urandom, $urandom};
      slow <= 1'($urandom_range(1));
      @(posedge core_clk);
      rd(8'h00, 8'h1C);
      xfer(1'b0, -1);
    end
    slow <= 1'b1;
    w = '{16'($urandom_range(32767)), 16'h7FFF};
    wr(8'hF5, 8'h01);
    xfer(1'b0, -1);
    {m_aqfs, m_tfs} = {w[0], w[1]};
    chk_val(aqfs, m_aqfs);
    chk_val(tfs, m_tfs);
    w = '{16'h8000};
    wr(8'hF5, 8'h01);
    xfer(1'b0, -1);
    chk_val(aqfs, m_aqfs);
    w = '{16'($urandom_range(500)), 16'($urandom_range(6)), 16'h1234, 16'h1234};
    wr(8'hF5, 8'h08);
    xfer(1'b0, -1);
    {m_frost, m_ao1} = {w[0], w[1]};
    rd(8'h12, 8'h04);
    xfer(1'b0, -1);
    chk_val(frost, m_frost);
    chk_val(ao1, m_ao1);
    w.delete();
    repeat (22) w.push_back(16'($urandom));
    wr(8'hF5, 8'h0A);
    xfer(1'b0, -1);
    w.push_back(16'h0000);
    wr(8'hF5, 8'h09);
    exc(8'h10, 8'h03);
    xfer(1'b0, -1);
    slow <= 1'b0;
    foreach (fns[i]) begin
      rq = '{8'hF5, fns[i], 8'h00, 8'h00, 8'h00, 8'h01};
      exc(fns[i], 8'h01);
      xfer(1'b0, -1);
    end
    rd(8'h1B, 8'h02);
    exc(8'h03, 8'h02);
    xfer(1'b0, -1);
    rd(8'h00, 8'h00);
    exc(8'h03, 8'h03);
    xfer(1'b0, -1);
    rd(8'h00, 8'h01);
    ex.delete();
    xfer(1'b1, -1);
    rd(8'h00, 8'h01);
    ex.delete();
    xfer(1'b0, 3);
    rd(8'h00, 8'h01);
    rq[0] = 8'h3A;
    ex.delete();
    xfer(1'b0, -1);
    repeat (200) @(posedge core_clk);
    put(8'h55, 1'b0);
    repeat (57) @(posedge core_clk);
    gap = 0;
    rd(8'h00, 8'h01);
    ex.delete();
    xfer(1'b0, -1);
    gap = 200;
    w = '{16'h0003};
    wr(8'h00, 8'h09);
    ex.delete();
    xfer(1'b0, -1);
    chk_val(ao1, 16'h0003);
    m_ao1 = 16'h0003;
    rd(8'h13, 8'h01);
    xfer(1'b0, -1);
    final_report();
  end
endmodule // tb_rtu_slave
`default_nettype wire
